// file: hdl/ppm_pin_mux.sv
// Peripheral pin location mux for ports 0, 1 and 2
//
// Functional notes
// - Pin goes to an arbitrated peripheral only when its function select bit is 1.
// - Each serial unit and timer has a location bit picking location 1 or 2.
// - Serial unit zero pin order per location and mode.
// - Serial unit one pin order per location and mode.
// - Timer one channels 0..2 on port0 2..4 or port1 2..0.
// - Timer three channels 0,1 on port1 3,4 or port1 6,7.
// - Timer four channels 0,1 on port1 0,1 or port2 0,3.
// - Analogue, crystal and debug pins sit at fixed positions; audio has a location bit picking location 1 or 2.
// - Port0 priority field orders serial units and timer one on port0.
// - Serial zero UART without flow frees port0 bits 4,5.
// - Serial one UART without flow frees port0 bits 3,2.
// - Port1 bits 3,0 both low: serial zero wins port1 conflicts.
// - Port1 bit3 high, bit2 low: serial one beats serial zero and timer three.
// - Port1 bit1 low, bit0 high: timer one beats timer four and serial zero.
// - Port1 bit2 high: timer three beats serial one.
// - Port1 bit1 high: timer four beats timer one.
// - Enabled audio owns its pins over all but debug, even on GPIO pins.
// - Debug overrides select on its pins and drives data direction.
`timescale 1ns/1ps
module ppm_pin_mux
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Function select
  input wire logic [7:0] pin_function_select_p0,
  input wire logic [7:0] pin_function_select_p1,
  input wire logic [4:0] pin_function_select_p2,
  // Location control
  input wire logic serial0_location_bit,
  input wire logic serial1_location_bit,
  input wire logic timer_one_location_bit,
  input wire logic timer_three_location_bit,
  input wire logic timer_four_location_bit,
  input wire logic audio_location_bit,
  // Priority control
  input wire logic [1:0] port0_priority_field,
  input wire logic port1_priority_bit3,
  input wire logic port1_priority_bit2,
  input wire logic port1_priority_bit1,
  input wire logic port1_priority_bit0,
  // Unit modes and overrides
  input wire logic serial_unit_zero_uart_mode,
  input wire logic serial_unit_zero_flow_enable,
  input wire logic serial_unit_one_uart_mode,
  input wire logic serial_unit_one_flow_enable,
  input wire logic audio_enable,
  input wire logic debug_enable,
  input wire logic crystal_pin_enable,
  input wire logic [ppm_pkg::PPM_ADC_PINS-1:0] analogue_input_enable,
  // General purpose side
  input wire logic [ppm_pkg::PPM_PINS-1:0] gpio_out,
  input wire logic [ppm_pkg::PPM_PINS-1:0] gpio_oe,
  output logic [ppm_pkg::PPM_PINS-1:0] gpio_in,
  // Serial unit zero
  input wire logic [3:0] serial_unit_zero_out,
  input wire logic [3:0] serial_unit_zero_oe,
  output logic [3:0] serial_unit_zero_in,
  // Serial unit one
  input wire logic [3:0] serial_unit_one_out,
  input wire logic [3:0] serial_unit_one_oe,
  output logic [3:0] serial_unit_one_in,
  // Timers
  input wire logic [2:0] timer_one_out,
  input wire logic [2:0] timer_one_oe,
  output logic [2:0] timer_one_in,
  input wire logic [1:0] timer_three_out,
  input wire logic [1:0] timer_three_oe,
  input wire logic [1:0] timer_four_out,
  input wire logic [1:0] timer_four_oe,
  // Audio serial interface
  input wire logic [3:0] audio_out,
  input wire logic [3:0] audio_oe,
  output logic [3:0] audio_in,
  // Debug interface
  input wire logic debug_data_pin_out,
  input wire logic debug_data_pin_oe,
  output logic debug_data_pin_in,
  output logic debug_clock_pin_in,
  // Package pins
  input wire logic [ppm_pkg::PPM_PINS-1:0] pin_in,
  output logic [ppm_pkg::PPM_PINS-1:0] pin_out,
  output logic [ppm_pkg::PPM_PINS-1:0] pin_oe,
  output logic [ppm_pkg::PPM_PINS-1:0] pin_analog
);
  import ppm_pkg::*;

  logic [PPM_PINS-1:0] pin_meta_q, pin_sync_q;
  logic [PPM_PINS-1:0] sel_all;
  logic [3:0] p1_prio;
  logic [PPM_UNITS-1:0] per_loc, no_flow;
  logic [PPM_SIGS-1:0] per_out [PPM_UNITS];
  logic [PPM_SIGS-1:0] per_oe [PPM_UNITS];
  logic [PPM_PINS-1:0] claim [PPM_UNITS];
  logic [1:0] fsel [PPM_UNITS][PPM_PINS];
  logic [2:0] win [PPM_PINS];
  ppm_owner_type own [PPM_PINS];
  logic [PPM_PINS-1:0] out_d, oe_d, ana_d, pin_out_q, pin_oe_q, pin_ana_q;
  logic [PPM_SIGS-1:0] in_d [PPM_UNITS];
  logic [PPM_SIGS-1:0] in_q [PPM_UNITS];
  logic [PPM_SIGS-1:0] aud_in_d, aud_in_q;
  logic dbg_data_d, dbg_clk_d, dbg_data_q, dbg_clk_q;

  // Flatten configuration into per-unit arrays
  assign sel_all = {pin_function_select_p2, pin_function_select_p1, pin_function_select_p0};
  assign p1_prio = {port1_priority_bit3, port1_priority_bit2,
                    port1_priority_bit1, port1_priority_bit0};
  assign per_loc = {timer_four_location_bit, timer_three_location_bit,
                    timer_one_location_bit, serial1_location_bit, serial0_location_bit};
  assign no_flow = {3'h0, serial_unit_one_uart_mode & ~serial_unit_one_flow_enable,
                    serial_unit_zero_uart_mode & ~serial_unit_zero_flow_enable};
  assign per_out = '{serial_unit_zero_out, serial_unit_one_out, {1'b0, timer_one_out},
                     {2'h0, timer_three_out}, {2'h0, timer_four_out}};
  assign per_oe = '{serial_unit_zero_oe, serial_unit_one_oe, {1'b0, timer_one_oe},
                    {2'h0, timer_three_oe}, {2'h0, timer_four_oe}};

  // Pairwise precedence: true when unit a wins over unit b on one pin
  function automatic logic ppm_beats(input logic [2:0] a, input logic [2:0] b,
                                     input logic [1:0] f0, input logic [3:0] f1,
                                     input logic on_p1);
    logic [2:0] lo;
    logic [2:0] hi;
    logic lo_wins;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    lo_wins = 1'b1;
    if (!on_p1)
    begin
      if (lo == PPM_S0 && hi == PPM_S1)
        lo_wins = !(f0 == PPM_P0_S1_FIRST || f0 == PPM_P0_T1_OVER_S1);
      if (hi == PPM_T1)
        lo_wins = !f0[PPM_P0_T1_BIT];
    end
    else
    begin
      if (lo == PPM_S0 && hi == PPM_S1)
        lo_wins = !f1[PPM_P1_B3];
      if (lo == PPM_S0 && hi == PPM_T1)
        lo_wins = !f1[PPM_P1_B0];
      if (lo == PPM_S1 && hi == PPM_T3)
        lo_wins = !f1[PPM_P1_B2];
      if (lo == PPM_T1 && hi == PPM_T4)
        lo_wins = !f1[PPM_P1_B1];
    end
    return (a == lo) ? lo_wins : !lo_wins;
  endfunction

  // Claims, arbitration, overrides and input return path
  always_comb
  begin
    int pin;
    logic ok;
    logic found;
    logic any;
    pin = 0;
    ok = 1'b0;
    found = 1'b0;
    any = 1'b0;
    claim = '{default: '0};
    fsel = '{default: '0};
    in_d = '{default: '0};
    aud_in_d = PPM_SIG_RST;
    dbg_data_d = 1'b0;
    dbg_clk_d = 1'b0;
    // Each unit claims the pins of its chosen location; free flow pins stay unclaimed
    for (int k = 0; k < PPM_UNITS; k++)
    begin
      for (int f = 0; f < PPM_SIGS; f++)
      begin
        pin = int'(per_loc[k] ? PPM_MAP_ALT2[k][f] : PPM_MAP_ALT1[k][f]);
        if (f < int'(PPM_SIG_CNT[k]) && !(no_flow[k] && f < PPM_FLOW_SIGS))
        begin
          claim[k][pin] = 1'b1;
          fsel[k][pin] = 2'(f);
        end
      end
    end
    for (int p = 0; p < PPM_PINS; p++)
    begin
      found = 1'b0;
      any = 1'b0;
      win[p] = PPM_S0;
      // Winner beats every other claimant; an inconclusive set falls to the lowest unit
      for (int k = 0; k < PPM_UNITS; k++)
      begin
        any = any | claim[k][p];
        if (claim[k][p] && !found)
        begin
          ok = 1'b1;
          for (int j = 0; j < PPM_UNITS; j++)
            if (j != k && claim[j][p] &&
                !ppm_beats(3'(k), 3'(j), port0_priority_field, p1_prio, p >= PPM_P0_PINS))
              ok = 1'b0;
          if (ok)
          begin
            win[p] = 3'(k);
            found = 1'b1;
          end
        end
      end
      if (!found)
        for (int k = PPM_UNITS - 1; k >= 0; k--)
          if (claim[k][p])
            win[p] = 3'(k);
      own[p] = PPM_OWN_GPIO;
      out_d[p] = gpio_out[p];
      oe_d[p] = gpio_oe[p];
      ana_d[p] = 1'b0;
      if (sel_all[p] && any)
      begin
        own[p] = PPM_OWN_PERIPH;
        out_d[p] = per_out[win[p]][fsel[win[p]][p]];
        oe_d[p] = per_oe[win[p]][fsel[win[p]][p]];
      end
      // Analogue use takes the pin away from GPIO and the arbitrated units; audio and debug still override it
      if ((p < PPM_ADC_PINS && analogue_input_enable[p]) ||
          (crystal_pin_enable && PPM_XTAL_PINS[p]))
      begin
        own[p] = PPM_OWN_ANALOG;
        out_d[p] = 1'b0;
        oe_d[p] = 1'b0;
        ana_d[p] = 1'b1;
      end
    end
    // Audio wins regardless of select, placed after the others to override them
    if (audio_enable)
      for (int f = 0; f < PPM_SIGS; f++)
      begin
        pin = int'(audio_location_bit ? PPM_AUD_ALT2[f] : PPM_AUD_ALT1[f]);
        own[pin] = PPM_OWN_AUDIO;
        out_d[pin] = audio_out[f];
        oe_d[pin] = audio_oe[f];
        ana_d[pin] = 1'b0;
      end
    // Debug last: it overrides even the audio interface
    if (debug_enable)
    begin
      own[PPM_DBG_CLK_PIN] = PPM_OWN_DEBUG;
      out_d[PPM_DBG_CLK_PIN] = 1'b0;
      oe_d[PPM_DBG_CLK_PIN] = 1'b0;
      ana_d[PPM_DBG_CLK_PIN] = 1'b0;
      own[PPM_DBG_DATA_PIN] = PPM_OWN_DEBUG;
      out_d[PPM_DBG_DATA_PIN] = debug_data_pin_out;
      oe_d[PPM_DBG_DATA_PIN] = debug_data_pin_oe;
      ana_d[PPM_DBG_DATA_PIN] = 1'b0;
    end
    // Only the final owner's return path sees the pin level
    for (int p = 0; p < PPM_PINS; p++)
    begin
      case (own[p])
        PPM_OWN_PERIPH: in_d[win[p]][fsel[win[p]][p]] = pin_sync_q[p];
        PPM_OWN_DEBUG:
        begin
          if (p == int'(PPM_DBG_CLK_PIN))
            dbg_clk_d = pin_sync_q[p];
          else
            dbg_data_d = pin_sync_q[p];
        end
        default: ;
      endcase
    end
    for (int f = 0; f < PPM_SIGS; f++)
    begin
      pin = int'(audio_location_bit ? PPM_AUD_ALT2[f] : PPM_AUD_ALT1[f]);
      if (own[pin] == PPM_OWN_AUDIO)
        aud_in_d[f] = pin_sync_q[pin];
    end
  end

  // Two-stage synchroniser for the asynchronous pin levels
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_q <= PPM_PIN_RST;
      pin_sync_q <= PPM_PIN_RST;
    end
    else
    begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Registered pin drive, so the pads never see arbitration glitches
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out_q <= PPM_PIN_RST;
      pin_oe_q <= PPM_PIN_RST;
      pin_ana_q <= PPM_PIN_RST;
    end
    else
    begin
      pin_out_q <= out_d;
      pin_oe_q <= oe_d;
      pin_ana_q <= ana_d;
    end
  end

  // Registered returns to the units
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      in_q <= '{default: PPM_SIG_RST};
      aud_in_q <= PPM_SIG_RST;
      dbg_data_q <= 1'b0;
      dbg_clk_q <= 1'b0;
    end
    else
    begin
      in_q <= in_d;
      aud_in_q <= aud_in_d;
      dbg_data_q <= dbg_data_d;
      dbg_clk_q <= dbg_clk_d;
    end
  end

  // Outputs; GPIO reads see the pin level whatever the owner
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_analog = pin_ana_q;
  assign gpio_in = pin_sync_q;
  assign serial_unit_zero_in = in_q[PPM_S0];
  assign serial_unit_one_in = in_q[PPM_S1];
  assign timer_one_in = in_q[PPM_T1][2:0];
  assign audio_in = aud_in_q;
  assign debug_data_pin_in = dbg_data_q;
  assign debug_clock_pin_in = dbg_clk_q;

  // Checks on the registered pin drive
  default clocking ppm_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_gpio_keep;
    (!pin_function_select_p0[5] && !audio_enable && !analogue_input_enable[5])
      |=> pin_out[5] == $past(gpio_out[5]) && pin_oe[5] == $past(gpio_oe[5]);
  endproperty
  a_gpio_keep: assert property (p_gpio_keep) else $error("gpio pin lost");

  property p_s0_alt1;
    (pin_function_select_p0[3] && !serial0_location_bit && !audio_enable &&
     !analogue_input_enable[3] && port0_priority_field == PPM_P0_S0_FIRST)
      |=> pin_out[PPM_MAP_ALT1[0][2]] == $past(serial_unit_zero_out[2]);
  endproperty
  a_s0_alt1: assert property (p_s0_alt1) else $error("serial0 location 1 wrong");

  property p_s1_alt2;
    (pin_function_select_p1[7] && serial1_location_bit && !audio_enable &&
     !timer_three_location_bit)
      |=> pin_oe[PPM_MAP_ALT2[1][3]] == $past(serial_unit_one_oe[3]);
  endproperty
  a_s1_alt2: assert property (p_s1_alt2) else $error("serial1 location 2 wrong");

  property p_t1_alt2;
    (pin_function_select_p1[2] && timer_one_location_bit && !serial0_location_bit &&
     !audio_enable) |=> pin_out[PPM_MAP_ALT2[2][0]] == $past(timer_one_out[0]);
  endproperty
  a_t1_alt2: assert property (p_t1_alt2) else $error("timer one location 2 wrong");

  property p_t4_alt2;
    (pin_function_select_p2[3] && timer_four_location_bit && !audio_enable &&
     !crystal_pin_enable) |=> pin_out[PPM_MAP_ALT2[4][1]] == $past(timer_four_out[1]);
  endproperty
  a_t4_alt2: assert property (p_t4_alt2) else $error("timer four location 2 wrong");

  property p_p0_s1_first;
    (pin_function_select_p0[3] && !serial0_location_bit && !serial1_location_bit &&
     !analogue_input_enable[3] && port0_priority_field == PPM_P0_S1_FIRST &&
     !(serial_unit_one_uart_mode && !serial_unit_one_flow_enable))
      |=> pin_out[3] == $past(serial_unit_one_out[0]) && serial_unit_zero_in[2] == 1'b0;
  endproperty
  a_p0_s1_first: assert property (p_p0_s1_first) else $error("port0 priority lost");

  property p_s0_release;
    (pin_function_select_p0[5] && !serial0_location_bit && !serial1_location_bit &&
     serial_unit_zero_uart_mode && !serial_unit_zero_flow_enable && !audio_enable &&
     !analogue_input_enable[5] && port0_priority_field == PPM_P0_S0_FIRST)
      |=> pin_out[5] == $past(serial_unit_one_out[3]);
  endproperty
  a_s0_release: assert property (p_s0_release) else $error("flow pins not freed");

  property p_t4_over_t1;
    (pin_function_select_p1[0] && timer_one_location_bit && !timer_four_location_bit &&
     port1_priority_bit1 && !audio_enable)
      |=> pin_out[PPM_MAP_ALT1[4][0]] == $past(timer_four_out[0]);
  endproperty
  a_t4_over_t1: assert property (p_t4_over_t1) else $error("timer four not first");

  property p_s1_over_s0_p1;
    (pin_function_select_p1[5] && serial0_location_bit && serial1_location_bit &&
     port1_priority_bit3 && !port1_priority_bit2 &&
     !(serial_unit_one_uart_mode && !serial_unit_one_flow_enable))
      |=> pin_out[PPM_MAP_ALT2[1][0]] == $past(serial_unit_one_out[0]);
  endproperty
  a_s1_over_s0_p1: assert property (p_s1_over_s0_p1) else $error("port1 bit3 ignored");

  property p_audio_own;
    (audio_enable && !audio_location_bit && !analogue_input_enable[1])[*2]
      |=> pin_out[PPM_AUD_ALT1[0]] == $past(audio_out[0]) &&
          pin_oe[PPM_AUD_ALT1[0]] == $past(audio_oe[0]);
  endproperty
  a_audio_own: assert property (p_audio_own) else $error("audio pin not owned");

  property p_debug_own;
    debug_enable |=> pin_oe[PPM_DBG_DATA_PIN] == $past(debug_data_pin_oe) &&
                     pin_out[PPM_DBG_DATA_PIN] == $past(debug_data_pin_out) &&
                     !pin_oe[PPM_DBG_CLK_PIN];
  endproperty
  a_debug_own: assert property (p_debug_own) else $error("debug pin not owned");

  // Main scenarios
  c_s0_wins: cover property (pin_function_select_p0[3] && !serial0_location_bit ##1
                             pin_out[3] == serial_unit_zero_out[2]);
  c_audio_on: cover property (audio_enable ##1 audio_enable);
  c_debug_out: cover property (debug_enable && debug_data_pin_oe ##1 pin_oe[17]);
  c_flow_free: cover property (serial_unit_zero_uart_mode && !serial_unit_zero_flow_enable);

endmodule

// file: include/ppm_pkg.sv
// Package: pin map, unit codes, priority codes and reset values for the pin mux
package ppm_pkg;

  // Pin and unit counts (port0 0..7, port1 8..15, port2 16..20)
  localparam int PPM_PINS = 21;
  localparam int PPM_P0_PINS = 8;
  localparam int PPM_ADC_PINS = 8;
  localparam int PPM_UNITS = 5;
  localparam int PPM_SIGS = 4;
  localparam int PPM_FLOW_SIGS = 2;

  // Arbitrated unit codes
  localparam logic [2:0] PPM_S0 = 3'h0;
  localparam logic [2:0] PPM_S1 = 3'h1;
  localparam logic [2:0] PPM_T1 = 3'h2;
  localparam logic [2:0] PPM_T3 = 3'h3;
  localparam logic [2:0] PPM_T4 = 3'h4;

  // Signals per unit, and unused map slot
  localparam logic [2:0] PPM_SIG_CNT [PPM_UNITS] = '{3'h4, 3'h4, 3'h3, 3'h2, 3'h2};
  localparam logic [4:0] PPM_NO_PIN = 5'h1F;

  // Pin of each unit signal, location 1 (serial: SCK/RTS, SS/CTS, MOSI/TX, MISO/RX)
  localparam logic [4:0] PPM_MAP_ALT1 [PPM_UNITS][PPM_SIGS] = '{
    '{5'h05, 5'h04, 5'h03, 5'h02},
    '{5'h03, 5'h02, 5'h04, 5'h05},
    '{5'h02, 5'h03, 5'h04, PPM_NO_PIN},
    '{5'h0B, 5'h0C, PPM_NO_PIN, PPM_NO_PIN},
    '{5'h08, 5'h09, PPM_NO_PIN, PPM_NO_PIN}};

  // Pin of each unit signal, location 2
  localparam logic [4:0] PPM_MAP_ALT2 [PPM_UNITS][PPM_SIGS] = '{
    '{5'h0B, 5'h0A, 5'h0D, 5'h0C},
    '{5'h0D, 5'h0C, 5'h0E, 5'h0F},
    '{5'h0A, 5'h09, 5'h08, PPM_NO_PIN},
    '{5'h0E, 5'h0F, PPM_NO_PIN, PPM_NO_PIN},
    '{5'h10, 5'h13, PPM_NO_PIN, PPM_NO_PIN}};

  // Audio serial pins: clock, word select, RX, TX
  localparam logic [4:0] PPM_AUD_ALT1 [PPM_SIGS] = '{5'h01, 5'h00, 5'h0F, 5'h0E};
  localparam logic [4:0] PPM_AUD_ALT2 [PPM_SIGS] = '{5'h13, 5'h12, 5'h11, 5'h10};

  // Fixed function pins
  localparam logic [4:0] PPM_DBG_CLK_PIN = 5'h12;
  localparam logic [4:0] PPM_DBG_DATA_PIN = 5'h11;
  localparam logic [PPM_PINS-1:0] PPM_XTAL_PINS = 21'h180000;

  // Port0 priority field codes
  localparam logic [1:0] PPM_P0_S0_FIRST = 2'h0;
  localparam logic [1:0] PPM_P0_S1_FIRST = 2'h1;
  localparam logic [1:0] PPM_P0_T1_OVER_S1 = 2'h2;
  localparam int PPM_P0_T1_BIT = 1;

  // Port1 priority bit positions in the packed 4-bit vector
  localparam int PPM_P1_B0 = 0;
  localparam int PPM_P1_B1 = 1;
  localparam int PPM_P1_B2 = 2;
  localparam int PPM_P1_B3 = 3;

  // Reset values
  localparam logic [PPM_PINS-1:0] PPM_PIN_RST = 21'h000000;
  localparam logic [PPM_SIGS-1:0] PPM_SIG_RST = 4'h0;

  // Owner of a pin after all overrides
  typedef enum logic [2:0] {
    PPM_OWN_GPIO = 3'b000,
    PPM_OWN_PERIPH = 3'b001,
    PPM_OWN_AUDIO = 3'b010,
    PPM_OWN_DEBUG = 3'b011,
    PPM_OWN_ANALOG = 3'b100
  } ppm_owner_type;

endpackage

// file: sim/ppm_pad_model.sv
// Package pad model standing at the far side of the pin mux
`timescale 1ns/1ps
module ppm_pad_model
(
  // Mux drive side
  input wire logic [ppm_pkg::PPM_PINS-1:0] pin_out,
  input wire logic [ppm_pkg::PPM_PINS-1:0] pin_oe,
  // External driver on the board
  input wire logic [ppm_pkg::PPM_PINS-1:0] ext_en,
  input wire logic [ppm_pkg::PPM_PINS-1:0] ext_val,
  // Resolved pad level
  output logic [ppm_pkg::PPM_PINS-1:0] pin_in
);
  import ppm_pkg::*;
  // Mux wins over board; undriven pads float high through the pull-up
  assign pin_in = (pin_out & pin_oe) | (ext_val & ext_en & ~pin_oe) | (~ext_en & ~pin_oe);
endmodule

// file: sim/ppm_pin_mux_bench.sv
// Self-checking bench for the peripheral pin location mux
`timescale 1ns/1ps
module ppm_pin_mux_bench;
  import ppm_pkg::*;
  // One arbitration case: config, unit drive levels, probed pin, expected out/oe
  typedef struct packed
  {
    logic [4:0] loc;
    logic [1:0] p0f;
    logic [3:0] p1;
    logic [3:0] md;
    logic [4:0] uo;
    logic sel;
    logic [4:0] pin;
    logic eo;
    logic eoe;
  } ppm_row_type;
  // Units in loc/uo: {t4,t3,t1,s1,s0}; md: {uart1,flow1,uart0,flow0}
  // Placements keep at most two claimants per pin, all conclusive
  ppm_row_type rows [0:18] = '{
    '{5'h04, 2'h0, 4'h0, 4'h0, 5'h01, 1'h1, 5'h03, 1'h1, 1'h1},
    '{5'h04, 2'h1, 4'h0, 4'h0, 5'h01, 1'h1, 5'h03, 1'h0, 1'h1},
    '{5'h01, 2'h2, 4'h0, 4'h0, 5'h02, 1'h1, 5'h04, 1'h0, 1'h1},
    '{5'h02, 2'h3, 4'h0, 4'h0, 5'h01, 1'h1, 5'h02, 1'h0, 1'h1},
    '{5'h02, 2'h0, 4'h0, 4'h0, 5'h01, 1'h1, 5'h02, 1'h1, 1'h1},
    '{5'h04, 2'h0, 4'h0, 4'h2, 5'h01, 1'h1, 5'h05, 1'h0, 1'h1},
    '{5'h04, 2'h0, 4'h0, 4'h3, 5'h01, 1'h1, 5'h05, 1'h1, 1'h1},
    '{5'h04, 2'h1, 4'h0, 4'h8, 5'h01, 1'h1, 5'h03, 1'h1, 1'h1},
    '{5'h1B, 2'h0, 4'h0, 4'h0, 5'h01, 1'h1, 5'h0D, 1'h1, 1'h1},
    '{5'h1B, 2'h0, 4'h8, 4'h0, 5'h01, 1'h1, 5'h0D, 1'h0, 1'h1},
    '{5'h1B, 2'h0, 4'h8, 4'h0, 5'h08, 1'h1, 5'h0E, 1'h0, 1'h1},
    '{5'h1B, 2'h0, 4'h4, 4'h0, 5'h08, 1'h1, 5'h0E, 1'h1, 1'h1},
    '{5'h0F, 2'h0, 4'h0, 4'h2, 5'h01, 1'h1, 5'h0A, 1'h0, 1'h1},
    '{5'h0F, 2'h0, 4'h0, 4'h3, 5'h01, 1'h1, 5'h0A, 1'h1, 1'h1},
    '{5'h0F, 2'h0, 4'h1, 4'h3, 5'h01, 1'h1, 5'h0A, 1'h0, 1'h1},
    '{5'h0F, 2'h0, 4'h2, 4'h0, 5'h10, 1'h1, 5'h09, 1'h1, 1'h1},
    '{5'h0F, 2'h0, 4'h1, 4'h0, 5'h10, 1'h1, 5'h09, 1'h0, 1'h1},
    '{5'h1B, 2'h0, 4'h0, 4'h0, 5'h10, 1'h1, 5'h10, 1'h1, 1'h1},
    '{5'h04, 2'h0, 4'h0, 4'h0, 5'h01, 1'h0, 5'h03, 1'h0, 1'h0}
  };
  // Stimulus and observed signals
  logic core_clk;
  logic rst;
  logic [7:0] sel0, sel1, adc;
  logic [4:0] sel2, loc, uo;
  logic [1:0] p0f;
  logic [3:0] p1, md, aout, aoe, s0i, s1i, ai;
  logic [2:0] t1i;
  logic aloc, aen, den, xen, ddo, ddoe, ddi, dci;
  logic [PPM_PINS-1:0] gout, goe, gin, pin_in, pin_out, pin_oe, pin_an, ext_en, ext_val;
  int miscompares;
  int cmp_count;
  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;
  // Device under test; each unit drives its own level on every signal
  ppm_pin_mux i_ppm_pin_mux (.core_clk(core_clk), .rst(rst), .pin_function_select_p0(sel0),
    .pin_function_select_p1(sel1), .pin_function_select_p2(sel2),
    .serial0_location_bit(loc[0]), .serial1_location_bit(loc[1]),
    .timer_one_location_bit(loc[2]), .timer_three_location_bit(loc[3]),
    .timer_four_location_bit(loc[4]), .audio_location_bit(aloc),
    .port0_priority_field(p0f), .port1_priority_bit3(p1[3]), .port1_priority_bit2(p1[2]),
    .port1_priority_bit1(p1[1]), .port1_priority_bit0(p1[0]),
    .serial_unit_zero_uart_mode(md[1]), .serial_unit_zero_flow_enable(md[0]),
    .serial_unit_one_uart_mode(md[3]), .serial_unit_one_flow_enable(md[2]),
    .audio_enable(aen), .debug_enable(den), .crystal_pin_enable(xen),
    .analogue_input_enable(adc), .gpio_out(gout), .gpio_oe(goe), .gpio_in(gin),
    .serial_unit_zero_out({4{uo[0]}}), .serial_unit_zero_oe(4'hF), .serial_unit_zero_in(s0i),
    .serial_unit_one_out({4{uo[1]}}), .serial_unit_one_oe(4'hF), .serial_unit_one_in(s1i),
    .timer_one_out({3{uo[2]}}), .timer_one_oe(3'h7), .timer_one_in(t1i),
    .timer_three_out({2{uo[3]}}), .timer_three_oe(2'h3),
    .timer_four_out({2{uo[4]}}), .timer_four_oe(2'h3),
    .audio_out(aout), .audio_oe(aoe), .audio_in(ai), .debug_data_pin_out(ddo),
    .debug_data_pin_oe(ddoe), .debug_data_pin_in(ddi), .debug_clock_pin_in(dci),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_analog(pin_an));
  // Board side
  ppm_pad_model i_ppm_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  // Compare and count
  task automatic chk(input logic [PPM_PINS-1:0] got, input logic [PPM_PINS-1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Load one row; the mux answers one edge later, so settle two edges
  task automatic apply(input ppm_row_type r);
    @(posedge core_clk);
    loc <= r.loc;
    p0f <= r.p0f;
    p1 <= r.p1;
    md <= r.md;
    uo <= r.uo;
    sel0 <= {8{r.sel}};
    sel1 <= {8{r.sel}};
    sel2 <= {5{r.sel}};
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Verdict
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    {sel0, sel1, adc, sel2, loc, uo, p0f, p1, md, aout, aoe} = '0;
    {aloc, aen, den, xen, ddo, ddoe} = '0;
    {gout, goe, ext_en, ext_val} = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge core_clk);
    #1;
    chk(pin_oe | pin_out | gin, '0);
    @(posedge core_clk);
    rst <= 1'b0;
    // Arbitration table
    foreach (rows[i])
    begin
      apply(rows[i]);
      chk({19'h0, pin_out[rows[i].pin], pin_oe[rows[i].pin]},
          {19'h0, rows[i].eo, rows[i].eoe});
    end
    // Pin return path: only the winner hears the pad
    // Serial zero and timer one both drive high so their returns read back high
    apply(ppm_row_type'{5'h04, 2'h0, 4'h0, 4'h0, 5'h05, 1'h1, 5'h03, 1'h1, 1'h1});
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0, t1i, s0i[2], s1i[0], gin[3]}, {15'h0, 6'h3D});
    // Audio takes its pins even on general purpose select
    @(posedge core_clk);
    {sel0, sel1, sel2} <= '0;
    aen <= 1'b1;
    aout <= 4'hF;
    aoe <= 4'hF;
    adc <= 8'h40;
    repeat (2) @(posedge core_clk);
    #1;
    chk({19'h0, pin_out[1], pin_oe[1]}, {19'h0, 2'h3});
    chk({20'h0, pin_an[6]}, {20'h0, 1'h1});
    chk({17'h0, ai}, {17'h0, 4'hF});
    // Debug beats audio at the second location; crystal pin goes analogue
    @(posedge core_clk);
    aloc <= 1'b1;
    den <= 1'b1;
    ddoe <= 1'b1;
    ddo <= 1'b1;
    xen <= 1'b1;
    ext_en[18] <= 1'b1;
    ext_val[18] <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({19'h0, pin_out[17], pin_oe[17]}, {19'h0, 2'h3});
    chk({20'h0, pin_oe[18]}, '0);
    chk({19'h0, pin_out[19], pin_an[20]}, {19'h0, 2'h3});
    repeat (2) @(posedge core_clk);
    #1;
    chk({19'h0, dci, ddi}, {19'h0, 2'h3});
    report_and_stop();
  end
endmodule
